/* hw/pmic_ctrl_map.svh */
`ifndef PMIC_CTRL_MAP_SVH
`define PMIC_CTRL_MAP_SVH
// Address choices selected by factory_config_index
`define ADDR_CHOICE_0 7'h25
`define ADDR_CHOICE_1 7'h27
`define ADDR_CHOICE_2 7'h67
`define ADDR_CHOICE_3 7'h6B
// Direction bit values
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1
// Register indices of the small volatile map reached over the serial port
`define REG_CTRL 8'h00
`define REG_MASK 8'h01
`define REG_SLEEP_CFG 8'h02
`define REG_DEEP_CFG 8'h03
`define REG_STATUS 8'h04
// Field positions in the control register
`define CTRL_SLEEP_REQ 0
`define CTRL_SLEEP_EN 1
`define CTRL_DEEP_REQ 2
`define CTRL_DEEP_ARM 3
`define CTRL_DEEP_PIN_EN 4
// Thermal interrupt mask position in the mask register
`define MASK_THERMAL 5
// Reset values
`define CTRL_RESET 8'h00
`define MASK_RESET 8'h00
`define SLEEP_CFG_RESET 8'h00
`define DEEP_CFG_RESET 8'h00
// Fault retry wait
`define RETRY_WAIT_MS 100
`define CLK_HZ 25000000
// Divide first so the product stays inside a 32-bit int
`define RETRY_CYCLES (`RETRY_WAIT_MS * (`CLK_HZ / 1000))
// Synchroniser reset: clock and data lines idle high, monitors and enable pin low
`define PIN_SYNC_RESET 8'h03
`endif

/* hw/pmic_ctrl_pkg.sv */
package pmic_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_COLD = 3'b000,
    ST_SEQ_START = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_SLEEP = 3'b011,
    ST_DEEP = 3'b100,
    ST_VFAULT = 3'b101,
    ST_THERMAL = 3'b110
  } ctrl_state_t;

  // Monitor inputs from the analog side
  typedef struct packed {
    logic vin_valid;
    logic input_undervoltage_threshold;
    logic reg_ov;
    logic reg_uv;
    logic thermal;
  } monitor_t;

  // Per-output drive: three bucks then two linear regulators
  typedef struct packed {
    logic [4:0] enable;
    logic [2:0] buck_alt;
  } rail_ctrl_t;
endpackage

/* hw/pmic_power_state_controller.sv */
`include "pmic_ctrl_map.svh"
module pmic_power_state_controller #(
  parameter int unsigned RETRY_CYCLES = `RETRY_CYCLES,
  parameter int unsigned SEQ_DELAY = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] factory_config_index,
  input wire pmic_ctrl_pkg::monitor_t monitor,
  input wire logic power_enable_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output pmic_ctrl_pkg::rail_ctrl_t rail_ctrl,
  output logic [2:0] reset_out_n,
  output logic power_good,
  output logic thermal_irq,
  output pmic_ctrl_pkg::ctrl_state_t state
);
  import pmic_ctrl_pkg::*;

  // Two-flop synchronisers for the monitor, enable and serial pin inputs; factory_config_index is used unsynchronised
  logic [7:0] sync1, sync2;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= `PIN_SYNC_RESET; // Idle-high bus lines avoid a false edge after reset
      sync2 <= `PIN_SYNC_RESET;
    end else begin
      sync1 <= {monitor, power_enable_pin, scl_in, sda_in};
      sync2 <= sync1;
    end
  end
  logic vin_valid, input_undervoltage_threshold, reg_ov, reg_uv, over_temp, pen, scl, sda_s;
  assign {vin_valid, input_undervoltage_threshold, reg_ov, reg_uv, over_temp, pen, scl, sda_s} = sync2;
  logic scl_d, sda_d, pen_d;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      pen_d <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda_s;
      pen_d <= pen;
    end
  end
  logic start_cond, stop_cond, scl_rise, scl_fall, pen_rise, pen_fall;
  assign start_cond = scl && sda_d && !sda_s;
  assign stop_cond = scl && !sda_d && sda_s;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign pen_rise = pen && !pen_d;
  assign pen_fall = !pen && pen_d;

  // Registers
  logic [7:0] ctrl_reg, mask_reg, sleep_cfg, deep_cfg;
  logic fault, uv_reset, volt_fault;
  assign volt_fault = reg_ov || reg_uv;
  assign fault = volt_fault || over_temp;
  assign uv_reset = input_undervoltage_threshold || !vin_valid;

  // Address selection by factory index
  logic [6:0] my_addr;
  always_comb begin
    unique case (factory_config_index)
      2'd0: my_addr = `ADDR_CHOICE_0;
      2'd1: my_addr = `ADDR_CHOICE_1;
      2'd2: my_addr = `ADDR_CHOICE_2;
      2'd3: my_addr = `ADDR_CHOICE_3;
    endcase
  end

  // Serial slave: bit counter, shift register, phases
  typedef enum logic [2:0] {
    SP_IDLE = 3'b000,
    SP_ADDR = 3'b001,
    SP_INDEX = 3'b010,
    SP_WDATA = 3'b011,
    SP_RDATA = 3'b100,
    SP_ACK = 3'b101,
    SP_RACK = 3'b110
  } ser_phase_t;
  ser_phase_t phase, after_ack;
  logic [3:0] bitcnt;
  logic [7:0] shreg, index, rd_byte;
  logic engine_reset;
  logic wr_strobe;
  logic [7:0] wr_byte;
  ctrl_state_t next_state;
  // Being in cold reset or entering a low-power or fault state drops a transfer; leaving one keeps the ACK
  assign engine_reset = (state == ST_COLD) || ((next_state != state) &&
    (next_state inside {ST_COLD, ST_SLEEP, ST_DEEP, ST_VFAULT, ST_THERMAL}));

  always_comb begin
    unique case (index)
      `REG_CTRL: rd_byte = ctrl_reg;
      `REG_MASK: rd_byte = mask_reg;
      `REG_SLEEP_CFG: rd_byte = sleep_cfg;
      `REG_DEEP_CFG: rd_byte = deep_cfg;
      `REG_STATUS: rd_byte = {1'b0, state, over_temp, volt_fault, vin_valid, 1'b0};
      default: rd_byte = 8'h00;
    endcase
  end

  // Serial phase machine, sampling on SCL rise and driving on SCL fall
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= SP_IDLE;
      after_ack <= SP_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      index <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_byte <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (engine_reset || stop_cond) begin
        phase <= SP_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        phase <= SP_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (phase == SP_ADDR || phase == SP_INDEX || phase == SP_WDATA) begin
          shreg <= {shreg[6:0], sda_s};
          bitcnt <= bitcnt + 4'h1;
        end else if (phase == SP_RACK && sda_s) begin
          phase <= SP_IDLE; // Master NAK ends the read
        end
      end else if (scl_fall) begin
        if (phase == SP_ACK || phase == SP_RACK) begin
          sda_oe <= 1'b0;
          bitcnt <= 4'h0;
          phase <= after_ack;
          if (after_ack == SP_RDATA) begin
            sda_oe <= !rd_byte[7];
            shreg <= {rd_byte[6:0], 1'b0};
            bitcnt <= 4'h1;
            index <= index + 8'h01;
          end
        end else if (phase == SP_RDATA) begin
          if (bitcnt == 4'h8) begin
            sda_oe <= 1'b0;
            phase <= SP_RACK;
            after_ack <= SP_RDATA;
          end else begin
            sda_oe <= !shreg[7];
            shreg <= {shreg[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        end else if (bitcnt == 4'h8) begin
          unique case (phase)
            SP_ADDR: begin
              if (shreg[7:1] == my_addr) begin
                sda_oe <= 1'b1;
                phase <= SP_ACK;
                after_ack <= (shreg[0] == `DIR_READ) ? SP_RDATA : SP_INDEX;
              end else begin
                phase <= SP_IDLE;
              end
            end
            SP_INDEX: begin
              index <= shreg;
              sda_oe <= 1'b1;
              phase <= SP_ACK;
              after_ack <= SP_WDATA;
            end
            SP_WDATA: begin
              wr_strobe <= 1'b1;
              wr_byte <= shreg;
              sda_oe <= 1'b1;
              phase <= SP_ACK;
              after_ack <= SP_WDATA;
            end
            default: phase <= SP_IDLE;
          endcase
        end
      end
    end
  end

  // Write commits as the acknowledge for the data byte starts to be driven
  logic wr_commit;
  assign wr_commit = wr_strobe;

  // Register file; arm bit set by hardware wins over software
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
      sleep_cfg <= `SLEEP_CFG_RESET;
      deep_cfg <= `DEEP_CFG_RESET;
    end else if (state == ST_COLD) begin
      ctrl_reg <= `CTRL_RESET;
      mask_reg <= `MASK_RESET;
      sleep_cfg <= `SLEEP_CFG_RESET;
      deep_cfg <= `DEEP_CFG_RESET;
    end else begin
      if (wr_commit) begin
        unique case (index)
          `REG_CTRL: ctrl_reg <= wr_byte;
          `REG_MASK: mask_reg <= wr_byte;
          `REG_SLEEP_CFG: sleep_cfg <= wr_byte;
          `REG_DEEP_CFG: deep_cfg <= wr_byte;
          default: ;
        endcase
      end
      if (state == ST_DEEP && fault) begin
        ctrl_reg[`CTRL_DEEP_ARM] <= 1'b0;
      end else if (pen_rise) begin
        ctrl_reg[`CTRL_DEEP_ARM] <= 1'b1;
      end
    end
  end

  // Deep-sleep request latch from the pin falling edge
  logic pin_deep;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_deep <= 1'b0;
    end else if (state == ST_COLD || pen_rise || !ctrl_reg[`CTRL_DEEP_ARM]) begin
      pin_deep <= 1'b0;
    end else if (pen_fall) begin
      pin_deep <= 1'b1;
    end
  end

  logic sleep_cond, deep_cond;
  assign sleep_cond = ctrl_reg[`CTRL_SLEEP_REQ] && ctrl_reg[`CTRL_SLEEP_EN];
  assign deep_cond = ctrl_reg[`CTRL_DEEP_ARM] &&
    (ctrl_reg[`CTRL_DEEP_REQ] || pin_deep);

  // Sequencing and retry timer
  logic [31:0] timer;
  // Any fault in deep sleep goes to active first; a lasting fault moves on from there
  always_comb begin
    next_state = state;
    if (uv_reset) begin
      next_state = ST_COLD;
    end else if (state == ST_DEEP && fault) begin
      next_state = ST_ACTIVE;
    end else if (over_temp && state != ST_COLD) begin
      next_state = ST_THERMAL;
    end else begin
      unique case (state)
        ST_COLD: next_state = ST_SEQ_START;
        ST_SEQ_START: if (timer >= SEQ_DELAY) next_state = ST_ACTIVE;
        ST_VFAULT: if (timer >= RETRY_CYCLES) next_state = ST_ACTIVE;
        ST_THERMAL: next_state = ST_SEQ_START; // Die has cooled
        default: begin
          if (volt_fault) next_state = ST_VFAULT;
          else if (deep_cond) next_state = ST_DEEP;
          else if (sleep_cond) next_state = ST_SLEEP;
          else next_state = ST_ACTIVE;
        end
      endcase
    end
  end

  // State register with timer that restarts on every change
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_COLD;
      timer <= 32'h0000_0000;
    end else begin
      state <= next_state;
      timer <= (next_state != state) ? 32'h0000_0000 : timer + 32'h0000_0001;
    end
  end

  // Rail targets; an all-off target applies at once, any other after the sequencing delay
  rail_ctrl_t target;
  always_comb begin
    target = '0;
    unique case (state)
      ST_ACTIVE, ST_SEQ_START: target.enable = 5'h1F;
      ST_SLEEP: begin
        target.enable = sleep_cfg[4:0];
        target.buck_alt = sleep_cfg[7:5] & sleep_cfg[2:0];
      end
      ST_DEEP: begin
        target.enable = deep_cfg[4:0];
        target.buck_alt = deep_cfg[7:5] & deep_cfg[2:0];
      end
      default: target = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rail_ctrl <= '0;
      reset_out_n <= 3'h0;
      power_good <= 1'b0;
      thermal_irq <= 1'b0;
    end else begin
      if (target.enable == 5'h00 || timer >= SEQ_DELAY) rail_ctrl <= target;
      reset_out_n <= (state == ST_ACTIVE || state == ST_SLEEP || state == ST_DEEP) ?
        3'h7 : 3'h0;
      power_good <= (state == ST_ACTIVE);
      thermal_irq <= over_temp && !mask_reg[`MASK_THERMAL];
    end
  end
endmodule // pmic_power_state_controller

/* verification/pmic_ctrl_checker.sv */
module pmic_ctrl_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire pmic_ctrl_pkg::monitor_t monitor,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire pmic_ctrl_pkg::rail_ctrl_t rail_ctrl,
  input wire logic [2:0] reset_out_n,
  input wire logic power_good,
  input wire pmic_ctrl_pkg::ctrl_state_t state
);
  timeunit 1ns;
  timeprecision 1ns;
  import pmic_ctrl_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // Outputs are registered, so the second cycle in a state is the first one judged
  property all_off(ctrl_state_t st);
    state == st ##1 state == st |-> rail_ctrl.enable == 5'h00 && reset_out_n == 3'h0;
  endproperty

  a_cold_all_off: assert property (all_off(ST_COLD))
    else $error("rails or resets active in cold reset");
  a_thermal_all_off: assert property (all_off(ST_THERMAL))
    else $error("rails or resets active in thermal state");
  a_vfault_all_off: assert property (all_off(ST_VFAULT))
    else $error("rails or resets active in voltage fault");
  a_seq_no_good: assert property (state == ST_SEQ_START |-> !power_good)
    else $error("power good during sequence start");
  a_cold_exit: assert property (
    (state == ST_COLD && monitor.vin_valid && !monitor.input_undervoltage_threshold)[*5] |=> state != ST_COLD)
    else $error("stuck in cold reset with valid supply");
  a_uv_to_cold: assert property (monitor.input_undervoltage_threshold |-> ##[1:6] state == ST_COLD)
    else $error("undervoltage did not reach cold reset");
  a_thermal_entry: assert property (
    (monitor.thermal && !monitor.input_undervoltage_threshold && !monitor.reg_ov && !monitor.reg_uv
     && state != ST_COLD)[*5] |-> state == ST_THERMAL)
    else $error("over temperature not in thermal state");
  a_sda_low_only: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line changed while clock high");
  a_cold_quiet: assert property (state == ST_COLD |-> !sda_oe)
    else $error("serial answer in cold reset");

  c_sleep: cover property (state == ST_SLEEP);
  c_deep: cover property (state == ST_DEEP);
  c_vfault: cover property (state == ST_VFAULT);
  c_ack: cover property ($rose(sda_oe));
endmodule // pmic_ctrl_checker

/* verification/i2c_host_model.sv */
module i2c_host_model (
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Eight clocks a phase leave room for the input synchronisers
  localparam int PH = 8;

  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end

  task automatic half();
    repeat (PH) @(negedge sys_clk);
  endtask

  // Data moves a cycle after the clock falls, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    @(negedge sys_clk);
    sda = b;
    half();
    scl = 1'h1;
    half();
    r = sda & ~sda_oe;
    scl = 1'h0;
  endtask

  task automatic start();
    @(negedge sys_clk);
    sda = 1'h1;
    half();
    scl = 1'h1;
    half();
    sda = 1'h0;
    half();
    scl = 1'h0;
  endtask

  task automatic stop();
    @(negedge sys_clk);
    sda = 1'h0;
    half();
    scl = 1'h1;
    half();
    sda = 1'h1;
    half();
  endtask

  // Byte out MSB first, ninth bit m is released (1) or an acknowledge (0)
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(m, r);
    ack = ~r;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] i, d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({a, 1'h0}, 1'h1, q, k0);
    xfer(i, 1'h1, q, k1);
    xfer(d, 1'h1, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] i, output logic [7:0] d);
    logic k;
    start();
    xfer({a, 1'h0}, 1'h1, d, k);
    xfer(i, 1'h1, d, k);
    start();
    xfer({a, 1'h1}, 1'h1, d, k);
    xfer(8'hFF, 1'h1, d, k);
    stop();
  endtask

  task automatic probe(input logic [6:0] a, output logic ok);
    logic [7:0] q;
    start();
    xfer({a, 1'h0}, 1'h1, q, ok);
    stop();
  endtask
endmodule // i2c_host_model

/* verification/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pmic_ctrl_pkg::*;
  logic sys_clk;
  logic reset_n;
  logic [1:0] cfg;
  monitor_t mon;
  logic pin;
  logic scl;
  logic host_sda;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  rail_ctrl_t rails;
  logic [2:0] rst_out_n;
  logic good;
  logic irq;
  ctrl_state_t state;
  logic k;
  logic [7:0] d;
  int n_errors = 0;
  int num_checks = 0;
  localparam logic [6:0] ADDRS [4] = '{7'h25, 7'h27, 7'h67, 7'h6B};
  localparam logic [7:0] SLP [3] = '{8'h01, 8'h02, 8'h03};

  // Open-drain data line with pull-up
  assign sda_in = host_sda & ~sda_oe;

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  pmic_power_state_controller #(.RETRY_CYCLES(50), .SEQ_DELAY(16)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .factory_config_index(cfg), .monitor(mon),
    .power_enable_pin(pin), .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .rail_ctrl(rails), .reset_out_n(rst_out_n), .power_good(good),
    .thermal_irq(irq), .state(state));
  i2c_host_model host (.sys_clk(sys_clk), .sda_oe(sda_oe), .scl(scl), .sda(host_sda));

  task automatic check(input string w, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, exp, got);
    end
  endtask

  // Bounded wait; long enough for the shortened retry and sequencing delays
  task automatic wait_st(input ctrl_state_t s);
    for (int i = 0; i < 300 && state !== s; i++) @(negedge sys_clk);
    check("state", 8'(state), 8'(s));
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    mon = '0;
    mon.vin_valid = 1'h1;
    pin = 1'h0;
    cfg = 2'h0;
    reset_n = 1'h0;
    repeat (4) @(negedge sys_clk);
    check("rails", rails, 8'h00);
    check("resets", 8'(rst_out_n), 8'h00);
    reset_n = 1'h1;
    wait_st(ST_SEQ_START);
    check("good", 8'(good), 8'h00);
    wait_st(ST_ACTIVE);
    repeat (2) @(negedge sys_clk);
    check("good", 8'(good), 8'h01);
    check("enables", 8'(rails.enable), 8'h1F);
    $display("done reset");
    // Each factory choice answers its own address and refuses the one at index i ^ 1
    for (int i = 0; i < 4; i++) begin
      cfg = i[1:0];
      host.probe(ADDRS[i], k);
      check("ack", 8'(k), 8'h01);
      host.probe(ADDRS[i ^ 1], k);
      check("nak", 8'(k), 8'h00);
    end
    cfg = 2'h0;
    $display("done address");
    host.wr(7'h25, 8'h01, 8'h20, k);
    host.rd(7'h25, 8'h01, d);
    check("mask", d, 8'h20);
    mon.thermal = 1'h1;
    wait_st(ST_THERMAL);
    check("irq", 8'(irq), 8'h00);
    repeat (2) @(negedge sys_clk);
    check("resets", 8'(rst_out_n), 8'h00);
    check("rails", rails, 8'h00);
    mon.thermal = 1'h0;
    wait_st(ST_ACTIVE);
    $display("done thermal");
    // Sleep config: bucks 0 and linear 3 on, buck 0 at alternate setpoint
    host.wr(7'h25, 8'h02, 8'h29, k);
    foreach (SLP[i]) begin
      host.wr(7'h25, 8'h00, SLP[i], k);
      repeat (40) @(negedge sys_clk);
      check("sleep", 8'(state), 8'((SLP[i] == 8'h03) ? ST_SLEEP : ST_ACTIVE));
    end
    check("rails", rails, 8'h49);
    host.wr(7'h25, 8'h00, 8'h00, k);
    check("ack", 8'(k), 8'h01);
    wait_st(ST_ACTIVE);
    $display("done sleep");
    pin = 1'h1;
    repeat (10) @(negedge sys_clk);
    host.rd(7'h25, 8'h00, d);
    check("arm", 8'(d[3]), 8'h01);
    pin = 1'h0;
    wait_st(ST_DEEP);
    repeat (40) @(negedge sys_clk);
    check("rails", rails, 8'h00);
    mon.reg_ov = 1'h1;
    @(negedge sys_clk);
    mon.reg_ov = 1'h0;
    wait_st(ST_ACTIVE);
    repeat (100) @(negedge sys_clk);
    host.rd(7'h25, 8'h00, d);
    check("arm", 8'(d[3]), 8'h00);
    check("state", 8'(state), 8'(ST_ACTIVE));
    $display("done deep");
    mon.reg_uv = 1'h1;
    wait_st(ST_VFAULT);
    mon.reg_uv = 1'h0;
    repeat (30) @(negedge sys_clk);
    check("state", 8'(state), 8'(ST_VFAULT));
    wait_st(ST_ACTIVE);
    $display("done fault");
    // An abandoned packet must not block the next one
    host.start();
    host.xfer(8'h4A, 1'h1, d, k);
    host.rd(7'h25, 8'h01, d);
    check("restart", d, 8'h20);
    mon.input_undervoltage_threshold = 1'h1;
    mon.thermal = 1'h1;
    wait_st(ST_COLD);
    mon.input_undervoltage_threshold = 1'h0;
    mon.thermal = 1'h0;
    wait_st(ST_ACTIVE);
    host.rd(7'h25, 8'h01, d);
    check("mask", d, 8'h00);
    $display("done undervoltage");
    report_and_stop();
  end
endmodule // tb_top

bind pmic_power_state_controller pmic_ctrl_checker chk (
  .sys_clk, .reset_n, .monitor, .scl_in, .sda_out, .sda_oe,
  .rail_ctrl, .reset_out_n, .power_good, .state
);
